// ---- verilog/rca_pkg.sv ----
/*
 * package for the control-location arbiter and link supervisor:
 * register offsets, field positions, reset values and tick timing.
 * assumes a single 100 MHz system clock.
 */
`default_nettype none

package rca_pkg;

   // register offsets (byte addresses, word aligned)
   localparam logic [7:0] CTRL_OFF     = 8'h00;
   localparam logic [7:0] TIMEOUT_OFF  = 8'h04;
   localparam logic [7:0] STATUS_OFF   = 8'h08;
   localparam logic [7:0] IRQ_STAT_OFF = 8'h0c;
   localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
   localparam logic [7:0] REQ_OFF      = 8'h14;

   // ctrl fields
   localparam int CTRL_LOCAL_BIT   = 0;
   localparam int CTRL_MON_EN_BIT  = 1;
   localparam int CTRL_KEEP_DC_BIT = 2;

   // req fields: enter and leave strobes, interface index
   localparam int REQ_ENTER_BIT = 0;
   localparam int REQ_LEAVE_BIT = 1;
   localparam int REQ_IF_LSB    = 4;

   // irq status fields
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_REFUSED_BIT = 1;
   localparam int IRQ_DROPPED_BIT = 2;
   localparam int IRQ_WIDTH       = 3;

   // status fields
   localparam int ST_LOC_LSB   = 0;
   localparam int ST_IF_LSB    = 4;
   localparam int ST_ANA_BIT   = 8;
   localparam int ST_MON_BIT   = 9;
   localparam int ST_DC_BIT    = 10;

   localparam int NUM_IF  = 4;
   localparam int IF_W    = 2;

   // reset values
   localparam logic [31:0] CTRL_RST    = 32'h0000_0002;
   localparam logic [15:0] TIMEOUT_RST = 16'h03e8;
   localparam logic [2:0]  MASK_RST    = 3'h0;

   // monitoring tick: timeout counted in whole milliseconds
   localparam int CLK_MHZ   = 100;
   localparam int TICK_US   = 1000;
   localparam int TICK_CYC  = TICK_US * CLK_MHZ;
   localparam logic [16:0] TICK_MAX = 17'(TICK_CYC - 1);

   typedef enum logic [1:0] {
      LOC_NONE,
      LOC_REMOTE,
      LOC_LOCAL
   } rca_loc_t;

endpackage : rca_pkg

`default_nettype wire

// ---- verilog/rca_watchdog.sv ----
/*
 * link supervisor timer: counts millisecond ticks while armed and
 * raises a one-cycle expiry. assumes the caller restarts it on every
 * message and arms it only for the digital interface in control.
 */
`default_nettype none

module rca_watchdog (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic        arm_in,
   input  wire logic        kick_in,
   input  wire logic [15:0] timeout_in,
   output logic             expire_out
);

   logic [16:0] tick_q;
   logic        tick;
   logic [15:0] cnt_q;
   logic [15:0] limit_q;
   logic        expire_q;

   ////////////////////////////////////////////////////////////////////
   // fixed-period tick
   assign tick = (tick_q == rca_pkg::TICK_MAX);

   always_ff @(posedge mclk_in) begin
      // a message restarts the tick too, else expiry could come early
      if (!rst_n_in || !arm_in || kick_in || tick) begin // RL10 RL17
         tick_q <= 17'h0;
      end else begin
         tick_q <= tick_q + 17'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interval counter; new limit taken while disarmed or when an interval ends
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         cnt_q    <= 16'h0;
         limit_q  <= rca_pkg::TIMEOUT_RST;
         expire_q <= 1'b0;
      end else begin
         expire_q <= 1'b0;
         if (!arm_in) begin // RL9
            cnt_q   <= 16'h0;
            limit_q <= timeout_in;
         end else if (kick_in) begin // RL10
            cnt_q <= 16'h0;
         end else if (tick) begin
            if (cnt_q + 16'h1 >= limit_q) begin
               cnt_q    <= 16'h0;
               limit_q  <= timeout_in; // RL14
               expire_q <= 1'b1; // RL17
            end else begin
               cnt_q <= cnt_q + 16'h1;
            end
         end
      end
   end

   assign expire_out = expire_q;

endmodule : rca_watchdog

`default_nettype wire

// ---- verilog/rca_arbiter.sv ----
/*
 * control-location arbiter with link supervisor and register port.
 * assumes a plain register master on the same clock and message
 * strobes from the digital interfaces on the same clock; analog pins
 * arrive asynchronously.
 */
`default_nettype none

// Behaviour
// [RL1] only one remote source at once
// [RL2] low request pin means analog holds remote
// [RL3] digital enter refused while analog active
// [RL4] analog pin ignored while digital holds
// [RL5] status and readback always answered
// [RL6] location is none, remote or local
// [RL7] local ends digital session for good
// [RL8] local suspends analog, resumes if still requested
// [RL9] monitor only digital interface in control
// [RL10] each message restarts the timeout
// [RL11] host sends messages within each interval
// [RL12] timeout leaves remote, dc per setting
// [RL13] monitoring enable changeable any time
// [RL14] new timeout taken after running interval
// [RL15] independent of network connection timeout
// [RL16] analog user asserts request pin first
// [RL17] tick-based count, one-cycle expiry event

module rca_arbiter (
   input  wire logic        mclk_in,
   input  wire logic        rst_n_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   input  wire logic        remote_req_n_in,
   input  wire logic        remote_standby_pin_in,
   input  wire logic [3:0]  msg_in,
   input  wire logic        dc_on_in,
   output logic             dc_off_out,
   output logic             refuse_out,
   output logic             remote_out,
   output logic             analog_out,
   output logic      [1:0]  owner_if_out,
   output logic             standby_out,
   output logic             irq_out
);

   rca_pkg::rca_loc_t loc_q;
   logic              dig_q;
   logic [1:0]        if_q;
   logic              local_q;
   logic              mon_en_q;
   logic              keep_dc_q;
   logic [15:0]       timeout_q;
   logic [2:0]        irq_stat_q;
   logic [2:0]        irq_mask_q;
   logic [31:0]       rdata_q;
   logic              refuse_q;
   logic              dc_off_q;
   logic [2:0]        ana_sync_q;
   logic              ana_q;
   logic [2:0]        sb_sync_q;
   logic              sb_q;
   logic              expire;
   logic              kick;
   logic              ena_req;
   logic              leave_req;
   logic [1:0]        req_if;
   logic              refused;
   logic              dropped;
   logic [2:0]        irq_set;

   ////////////////////////////////////////////////////////////////////
   // address decode used by reads and writes
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; change taken once stages two and three agree
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ana_sync_q <= 3'h7;
         ana_q      <= 1'b0;
         sb_sync_q  <= 3'h0;
         sb_q       <= 1'b0;
      end else begin
         ana_sync_q <= {ana_sync_q[1:0], remote_req_n_in};
         sb_sync_q  <= {sb_sync_q[1:0], remote_standby_pin_in};
         if (ana_sync_q[1] == ana_sync_q[2]) begin
            ana_q <= !ana_sync_q[2]; // RL2
         end
         if (sb_sync_q[1] == sb_sync_q[2]) begin
            sb_q <= sb_sync_q[2]; // RL16
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // request strobes written by software on behalf of a link
   assign ena_req   = wr_in && hit(addr_in, rca_pkg::REQ_OFF)
                      && wdata_in[rca_pkg::REQ_ENTER_BIT];
   assign leave_req = wr_in && hit(addr_in, rca_pkg::REQ_OFF)
                      && wdata_in[rca_pkg::REQ_LEAVE_BIT];
   assign req_if    = wdata_in[rca_pkg::REQ_IF_LSB +: rca_pkg::IF_W];

   // refused while analog holds, local is set, or another link owns
   assign refused = ena_req && (local_q || (ana_q && !dig_q) // RL3
                    || (dig_q && (req_if != if_q))); // RL1

   ////////////////////////////////////////////////////////////////////
   // location arbiter
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         dig_q <= 1'b0;
         if_q  <= 2'h0;
      end else if (local_q || expire) begin // RL7 RL12
         dig_q <= 1'b0;
      end else if (ena_req && !refused) begin
         dig_q <= 1'b1;
         if_q  <= req_if;
      end else if (leave_req && dig_q && req_if == if_q) begin
         dig_q <= 1'b0;
      end
   end

   assign dropped = dig_q && (local_q || expire);

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         loc_q <= rca_pkg::LOC_NONE;
      end else if (local_q) begin
         loc_q <= rca_pkg::LOC_LOCAL; // RL6 RL8
      end else if (dig_q || ana_q) begin
         loc_q <= rca_pkg::LOC_REMOTE; // RL4
      end else begin
         loc_q <= rca_pkg::LOC_NONE;
      end
   end

   // digital owner wins; analog shown only when no link holds
   assign remote_out   = (loc_q == rca_pkg::LOC_REMOTE);
   assign analog_out   = remote_out && !dig_q && ana_q; // RL1 RL4 RL8
   assign owner_if_out = if_q;
   assign standby_out  = sb_q;

   ////////////////////////////////////////////////////////////////////
   // link supervisor; separate from any network connection timer
   assign kick = dig_q && msg_in[if_q]; // RL10

   rca_watchdog u_wd (
      .mclk_in    (mclk_in),
      .rst_n_in   (rst_n_in),
      .arm_in     (dig_q && mon_en_q && !local_q), // RL9 RL13 RL15
      .kick_in    (kick),
      .timeout_in (timeout_q),
      .expire_out (expire)
   );

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         dc_off_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         dc_off_q <= expire && dc_on_in && !keep_dc_q; // RL12
         refuse_q <= refused; // RL3
      end
   end

   assign dc_off_out = dc_off_q;
   assign refuse_out = refuse_q;

   ////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         local_q   <= rca_pkg::CTRL_RST[rca_pkg::CTRL_LOCAL_BIT];
         mon_en_q  <= rca_pkg::CTRL_RST[rca_pkg::CTRL_MON_EN_BIT];
         keep_dc_q <= rca_pkg::CTRL_RST[rca_pkg::CTRL_KEEP_DC_BIT];
         timeout_q <= rca_pkg::TIMEOUT_RST;
         irq_mask_q <= rca_pkg::MASK_RST;
      end else if (wr_in) begin
         if (hit(addr_in, rca_pkg::CTRL_OFF)) begin
            local_q   <= wdata_in[rca_pkg::CTRL_LOCAL_BIT];
            mon_en_q  <= wdata_in[rca_pkg::CTRL_MON_EN_BIT]; // RL13
            keep_dc_q <= wdata_in[rca_pkg::CTRL_KEEP_DC_BIT];
         end else if (hit(addr_in, rca_pkg::TIMEOUT_OFF)) begin
            timeout_q <= wdata_in[15:0]; // RL14
         end else if (hit(addr_in, rca_pkg::IRQ_MASK_OFF)) begin
            irq_mask_q <= wdata_in[rca_pkg::IRQ_WIDTH-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sticky events, cleared by reading; a new event beats the clear
   assign irq_set = {dropped, refused, expire};

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= 3'h0;
      end else if (rd_in && hit(addr_in, rca_pkg::IRQ_STAT_OFF)) begin
         irq_stat_q <= irq_set;
      end else begin
         irq_stat_q <= irq_stat_q | irq_set;
      end
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////
   // read port; status never blocked by the owner
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 32'h0;
      end else if (rd_in) begin
         rdata_q <= 32'h0;
         if (hit(addr_in, rca_pkg::CTRL_OFF)) begin
            rdata_q[rca_pkg::CTRL_LOCAL_BIT]   <= local_q;
            rdata_q[rca_pkg::CTRL_MON_EN_BIT]  <= mon_en_q;
            rdata_q[rca_pkg::CTRL_KEEP_DC_BIT] <= keep_dc_q;
         end else if (hit(addr_in, rca_pkg::TIMEOUT_OFF)) begin
            rdata_q[15:0] <= timeout_q;
         end else if (hit(addr_in, rca_pkg::STATUS_OFF)) begin // RL5
            rdata_q[rca_pkg::ST_LOC_LSB +: 2]          <= loc_q;
            rdata_q[rca_pkg::ST_IF_LSB +: rca_pkg::IF_W] <= if_q;
            rdata_q[rca_pkg::ST_ANA_BIT]               <= analog_out;
            rdata_q[rca_pkg::ST_MON_BIT]               <= dig_q && mon_en_q;
            rdata_q[rca_pkg::ST_DC_BIT]                <= dc_on_in;
         end else if (hit(addr_in, rca_pkg::IRQ_STAT_OFF)) begin
            rdata_q[rca_pkg::IRQ_WIDTH-1:0] <= irq_stat_q;
         end else if (hit(addr_in, rca_pkg::IRQ_MASK_OFF)) begin
            rdata_q[rca_pkg::IRQ_WIDTH-1:0] <= irq_mask_q;
         end
      end else begin
         rdata_q <= 32'h0;
      end
   end

   assign rdata_out = rdata_q;

endmodule : rca_arbiter

`default_nettype wire

// ---- dv/rca_host_model.sv ----
/* host on the digital links: sends keep-alive messages.
   assumes msg_out feeds msg_in of the arbiter. */
`default_nettype none
module rca_host_model (
   input  wire logic       mclk_in,
   input  wire logic       keep_in,
   input  wire logic [1:0] if_in,
   output var  logic [3:0] msg_out = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] gap_q = 16'h0000;
   // one message each 20000 cycles, well inside 1 ms
   always @(posedge mclk_in) begin
      gap_q   <= (keep_in && gap_q != 16'h4e1f) ? gap_q + 16'h0001 : 16'h0000;
      msg_out <= (keep_in && gap_q == 16'h4e1f) ? 4'h1 << if_in : 4'h0;
   end
endmodule : rca_host_model
`default_nettype wire

// ---- dv/rca_arbiter_assertions.sv ----
/* port checker for the arbiter.
   assumes one clock, bound at the foot of this file. */
`default_nettype none
module rca_arbiter_assertions (
   input wire logic        mclk_in,
   input wire logic        rst_n_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   input wire logic        remote_req_n_in,
   input wire logic        remote_standby_pin_in,
   input wire logic        dc_on_in,
   input wire logic        dc_off_out,
   input wire logic        refuse_out,
   input wire logic        remote_out,
   input wire logic        analog_out,
   input wire logic [1:0]  owner_if_out,
   input wire logic        standby_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////
   a_one_source: assert property ($past(analog_out) |-> $stable(owner_if_out))
      else $error("digital owner taken while analog held control");
   a_owner_stable: assert property (remote_out && $past(remote_out) |-> $stable(owner_if_out))
      else $error("owner changed during a session");
   a_remote_cause: assert property ($rose(remote_out) |->
      $past(wr_in) || $past(wr_in, 2) || $past(wr_in, 3)
      || !$past(remote_req_n_in, 5))
      else $error("remote entered without a request");
   a_analog_drop: assert property (remote_req_n_in [*8] |=> !analog_out)
      else $error("analog held without request");
   a_refuse_cause: assert property (refuse_out |-> $past(wr_in))
      else $error("refusal without a request");
   a_dc_cause: assert property (dc_off_out |-> $past(dc_on_in))
      else $error("dc off without dc on");
   a_dc_pulse: assert property (dc_off_out |=> !dc_off_out)
      else $error("dc off longer than one cycle");
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
      else $error("read data outside read slot");
   a_standby_on: assert property (remote_standby_pin_in [*8] |=> standby_out)
      else $error("standby not followed");
   a_standby_off: assert property (!remote_standby_pin_in [*8] |=> !standby_out)
      else $error("standby not released");
endmodule : rca_arbiter_assertions
bind rca_arbiter rca_arbiter_assertions u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .remote_req_n_in(remote_req_n_in),
   .remote_standby_pin_in(remote_standby_pin_in), .dc_on_in(dc_on_in),
   .dc_off_out(dc_off_out), .refuse_out(refuse_out), .remote_out(remote_out),
   .analog_out(analog_out), .owner_if_out(owner_if_out), .standby_out(standby_out));
`default_nettype wire

// ---- dv/rca_arbiter_tb_top.sv ----
/* testbench for the arbiter: register tasks and sequences.
   assumes the host model and the bound checker. */
`default_nettype none
module rca_arbiter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, req_n = 1'b1, sb = 1'b0;
   logic dc_on = 1'b0, keep = 1'b0, dc_off, refuse, remote, analog, standby, irq;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [3:0]  msg;
   logic [1:0]  owner, hif = 2'h0;
   int miscompares = 0, check_count = 0, cyc = 0, n;
   always #5 mclk = ~mclk;
   rca_arbiter dut (.mclk_in(mclk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .remote_req_n_in(req_n),
      .remote_standby_pin_in(sb), .msg_in(msg), .dc_on_in(dc_on), .dc_off_out(dc_off),
      .refuse_out(refuse), .remote_out(remote), .analog_out(analog),
      .owner_if_out(owner), .standby_out(standby), .irq_out(irq));
   rca_host_model host (.mclk_in(mclk), .keep_in(keep), .if_in(hif), .msg_out(msg));
   ////////////////////////////////////////
   task automatic results;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic idle(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask : idle
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wrr
   // read data stand one cycle only, taken right after it settles
   task automatic rdd(input logic [7:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rdd
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      rdd(a);
      chk(nm, v, e);
   endtask : rdc
   // hang guard: the timeout case alone needs about 120k cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 140000) begin
         miscompares++;
         results();
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rdc("ctrl", 8'h00, rca_pkg::CTRL_RST);
      rdc("timeout", 8'h04, {16'h0000, rca_pkg::TIMEOUT_RST});
      rdc("mask", 8'h10, 32'h0);
      rdc("unmapped", 8'h18, 32'h0);
      wrr(8'h14, 32'h11);
      idle(3);
      rdc("status", 8'h08, 32'h211);
      wrr(8'h00, 32'h0);
      rdc("mon off", 8'h08, 32'h011);
      wrr(8'h00, 32'h6);
      rdc("keep dc", 8'h00, 32'h6);
      wrr(8'h14, 32'h21);
      idle(3);
      chk("irq masked", 32'(irq), 32'h0);
      rdc("second owner", 8'h0c, 32'h2);
      rdc("read clear", 8'h0c, 32'h0);
      req_n <= 1'b0;
      idle(10);
      chk("analog ignored", 32'(analog), 32'h0);
      rdc("still digital", 8'h08, 32'h211);
      wrr(8'h14, 32'h12);
      idle(10);
      chk("analog", 32'(analog), 32'h1);
      rdd(8'h0c);
      wrr(8'h14, 32'h01);
      #1;
      chk("refuse", 32'(refuse), 32'h1);
      idle(3);
      rdc("enter vs analog", 8'h0c, 32'h2);
      wrr(8'h00, 32'h3);
      idle(10);
      chk("analog local", 32'(analog), 32'h0);
      rdd(8'h08);
      chk("loc local", v & 32'h3, 32'h2);
      wrr(8'h00, 32'h2);
      idle(10);
      chk("analog back", 32'(analog), 32'h1);
      req_n <= 1'b1;
      sb <= 1'b1;
      idle(10);
      chk("standby", 32'(standby), 32'h1);
      wrr(8'h14, 32'h31);
      idle(3);
      chk("remote", 32'(remote), 32'h1);
      chk("owner", 32'(owner), 32'h3);
      rdd(8'h0c);
      wrr(8'h00, 32'h3);
      idle(3);
      chk("local drop", 32'(remote), 32'h0);
      rdc("dropped", 8'h0c, 32'h4);
      wrr(8'h00, 32'h2);
      idle(10);
      chk("no return", 32'(remote), 32'h0);
      dc_on <= 1'b1;
      wrr(8'h10, 32'h7);
      wrr(8'h04, 32'h1);
      wrr(8'h14, 32'h01);
      keep <= 1'b1;
      idle(25000);
      keep <= 1'b0;
      // last message near 20k in; plain arming would expire at 100k
      idle(80000);
      chk("kept alive", 32'(remote), 32'h1);
      n = 0;
      while (dc_off !== 1'b1 && n < 30000) begin
         idle(1);
         n++;
      end
      chk("dc off", 32'(dc_off), 32'h1);
      idle(3);
      chk("timeout drop", 32'(remote), 32'h0);
      chk("irq", 32'(irq), 32'h1);
      // expiry also flags the owner it drops
      rdc("timeout irq", 8'h0c, 32'h5);
      idle(2);
      chk("irq clear", 32'(irq), 32'h0);
      results();
   end
endmodule : rca_arbiter_tb_top
`default_nettype wire
